// ### design/trace_skid_buffer.v
// Purpose: two-entry buffer between the trace upload and the host side
// Assumes: same clock on both sides
// Notes:   in_ready depends only on fill level, never on out_ready
`timescale 1ns/1ps
`default_nettype none
module trace_skid_buffer #(
  parameter WIDTH = 8
) (
  input  wire             mclk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg             wr_q;
  reg             rd_q;
  reg [1:0]       cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
    if (!rst_b) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule // trace_skid_buffer
`default_nettype wire

// ### design/trace_trigger_defines.vh
// Purpose: constants for the trace trigger, delay and capture block
// Assumes: one clock, mclk at 125 MHz, one enable per target bus cycle
// Notes:   no registers reachable by software; commands are input pulses
// Summary of operation
// (RULE1) each preset command first erases all programmed trigger conditions
// (RULE2) after trigger, exactly delay-count bus cycles pass, then buffer freezes
// (RULE3) top-of-trace preset loads delay count with hex a0
// (RULE4) middle-of-trace preset loads delay count with hex 55
// (RULE5) bottom-of-trace preset loads delay count with 4
// (RULE6) delay count may also be written directly with any value
// (RULE7) small delay leaves most of the frozen buffer as pre-trigger cycles
// (RULE8) cycles numbered relative to trigger: trigger 0, earlier negative
// (RULE9) once frozen, recorded activity goes to host, pre-trigger cycles too
// (RULE10) reset-on-start enabled: starting capture pulses target reset
// (RULE11) reset-on-start disabled: starting leaves the target untouched
// (RULE12) startup enables reset-on-start; user may toggle it afterwards
// (RULE13) trigger on first qualifying bus cycle after start only
// (RULE14) trigger needs every programmed group condition true same cycle
// (RULE15) delay counter decrements per post-trigger cycle, freezes at zero
`ifndef TRACE_TRIGGER_DEFINES_VH
`define TRACE_TRIGGER_DEFINES_VH

`define DELAY_TOP        8'ha0
`define DELAY_MIDDLE     8'h55
`define DELAY_BOTTOM     8'h04
`define DELAY_RESET      8'ha0
`define TARGET_RESET_NS  80
// 80 ns at 8 ns per mclk, sized to the reset countdown register
`define TARGET_RESET_CYC 4'ha

`endif

// ### design/trace_trigger_delay_capture.v
// Purpose: trigger search, post-trigger delay, freeze and upload of a trace
// Assumes: bus_cycle_en pulses once per target bus cycle, same clock domain;
//          group_match bits come from the per-group truth tables
// Notes:   upload emits entries oldest first, each with a signed cycle number
`timescale 1ns/1ps
`default_nettype none
`include "trace_trigger_defines.vh"
module trace_trigger_delay_capture #(
  parameter GROUPS = 6,
  parameter SAMPLE = 48,
  parameter AW     = 8
) (
  input  wire              mclk,
  input  wire              rst_b,
  input  wire              bus_cycle_en,
  input  wire [SAMPLE-1:0] bus_sample,
  input  wire [GROUPS-1:0] group_match,
  input  wire [GROUPS-1:0] group_program,
  input  wire              startup,
  input  wire              preset_trigger_at_top,
  input  wire              preset_trigger_in_middle,
  input  wire              preset_trigger_at_bottom,
  input  wire              delay_write,
  input  wire [AW-1:0]     delay_value,
  input  wire              reset_on_start_set,
  input  wire              reset_on_start_clear,
  input  wire              start_capture,
  output reg  [GROUPS-1:0] group_enable,
  output reg  [AW-1:0]     post_trigger_delay_count,
  output reg               reset_on_start,
  output reg               target_reset,
  output reg               armed,
  output reg               frozen,
  output reg  [SAMPLE-1:0] upload_data,
  output reg  [AW:0]       upload_cycle,
  output reg               upload_valid,
  input  wire              upload_ready,
  output reg               upload_done
);
  localparam DEPTH = 1 << AW;
  localparam BW    = SAMPLE + AW + 1;
  localparam ST_IDLE   = 2'h0;
  localparam ST_ARMED  = 2'h1;
  localparam ST_DELAY  = 2'h2;
  localparam ST_UPLOAD = 2'h3;

  reg  [SAMPLE-1:0] trace_mem [0:DEPTH-1];
  reg  [1:0]        state_q;
  reg  [AW-1:0]     wr_ptr_q;
  reg  [AW-1:0]     delay_q;
  reg  [AW-1:0]     trig_ptr_q;
  reg  [AW-1:0]     rd_ptr_q;
  reg  [AW-1:0]     base_q;
  reg  [AW:0]       rd_left_q;
  reg               filled_q;
  reg  [3:0]        rst_cnt_q;
  reg               fetch_q;
  reg  [SAMPLE-1:0] fetch_data_q;
  reg  [AW:0]       fetch_cyc_q;
  wire              trig_hit;
  wire              any_preset;
  wire              buf_in_ready;
  wire              buf_out_valid;
  wire [BW-1:0]     buf_out;
  wire [BW-1:0]     buf_in;

  // all programmed groups must agree in the same cycle
  assign trig_hit = bus_cycle_en &
                    (&(group_match | ~group_enable)); // see RULE14
  assign any_preset = preset_trigger_at_top | preset_trigger_in_middle |
                      preset_trigger_at_bottom;
  assign buf_in = {fetch_cyc_q, fetch_data_q};

  // ----------------------------------------
  // trace memory: records every bus cycle until frozen
  // ----------------------------------------
  always @(posedge mclk) begin
    // the freezing edge must not overwrite the oldest entry
    if (bus_cycle_en && (state_q == ST_ARMED ||
        (state_q == ST_DELAY && delay_q != {AW{1'b0}}))) begin
      trace_mem[wr_ptr_q] <= bus_sample;
    end
  end

  // ----------------------------------------
  // setup: presets, delay count, reset-on-start
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!rst_b) begin
      group_enable             <= {GROUPS{1'b0}};
      post_trigger_delay_count <= `DELAY_RESET;
      reset_on_start           <= 1'b1;
    end else begin
      if (any_preset) begin
        group_enable <= {GROUPS{1'b0}}; // see RULE1
      end else begin
        group_enable <= group_enable | group_program;
      end
      if (delay_write) begin
        post_trigger_delay_count <= delay_value; // see RULE6
      end else if (preset_trigger_at_top) begin
        post_trigger_delay_count <= `DELAY_TOP; // see RULE3
      end else if (preset_trigger_in_middle) begin
        post_trigger_delay_count <= `DELAY_MIDDLE; // see RULE4
      end else if (preset_trigger_at_bottom) begin
        post_trigger_delay_count <= `DELAY_BOTTOM; // see RULE5
      end
      if (startup || reset_on_start_set) begin
        reset_on_start <= 1'b1; // see RULE12
      end else if (reset_on_start_clear) begin
        reset_on_start <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // capture state machine
  // ----------------------------------------
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_q      <= ST_IDLE;
      wr_ptr_q     <= {AW{1'b0}};
      base_q       <= {AW{1'b0}};
      delay_q      <= {AW{1'b0}};
      trig_ptr_q   <= {AW{1'b0}};
      rd_ptr_q     <= {AW{1'b0}};
      rd_left_q    <= {(AW+1){1'b0}};
      filled_q     <= 1'b0;
      rst_cnt_q    <= 4'h0;
      target_reset <= 1'b0;
      armed        <= 1'b0;
      frozen       <= 1'b0;
      upload_done  <= 1'b0;
      fetch_q      <= 1'b0;
      fetch_data_q <= {SAMPLE{1'b0}};
      fetch_cyc_q  <= {(AW+1){1'b0}};
    end else begin
      upload_done <= 1'b0;
      if (rst_cnt_q != 4'h0) begin
        rst_cnt_q <= rst_cnt_q - 4'h1;
      end
      target_reset <= (rst_cnt_q > 4'h1);
      if (fetch_q && buf_in_ready) begin
        fetch_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (start_capture) begin
            state_q  <= ST_ARMED;
            armed    <= 1'b1;
            frozen   <= 1'b0;
            wr_ptr_q <= {AW{1'b0}};
            filled_q <= 1'b0;
            if (reset_on_start) begin
              // this cycle plus countdown while above one gives the width
              rst_cnt_q    <= `TARGET_RESET_CYC; // see RULE10
              target_reset <= 1'b1;
            end // otherwise target left alone, see RULE11
          end
        end
        ST_ARMED: begin
          if (bus_cycle_en) begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (&wr_ptr_q) begin
              filled_q <= 1'b1;
            end
          end
          if (trig_hit) begin
            // first qualifying cycle wins; later ones ignored
            state_q    <= ST_DELAY; // see RULE13
            armed      <= 1'b0;
            trig_ptr_q <= wr_ptr_q;
            delay_q    <= post_trigger_delay_count;
          end
        end
        ST_DELAY: begin
          if (delay_q == {AW{1'b0}}) begin
            // pointer stops here; a small delay leaves mostly history
            state_q   <= ST_UPLOAD; // see RULE2, RULE7, RULE15
            frozen    <= 1'b1;
            rd_left_q <= filled_q ? DEPTH[AW:0] : {1'b0, wr_ptr_q};
            rd_ptr_q  <= filled_q ? wr_ptr_q : {AW{1'b0}};
            base_q    <= filled_q ? wr_ptr_q : {AW{1'b0}};
          end else if (bus_cycle_en) begin
            wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
            if (&wr_ptr_q) begin
              filled_q <= 1'b1;
            end
            delay_q <= delay_q - {{(AW-1){1'b0}}, 1'b1}; // see RULE15
          end
        end
        ST_UPLOAD: begin
          if (!fetch_q || buf_in_ready) begin
            if (rd_left_q != {(AW+1){1'b0}}) begin
              fetch_q      <= 1'b1;
              fetch_data_q <= trace_mem[rd_ptr_q]; // see RULE9
              // positions counted from the oldest entry, so a wrapped
              // buffer still numbers its history below zero
              fetch_cyc_q  <= {1'b0, rd_ptr_q - base_q} -
                              {1'b0, trig_ptr_q - base_q}; // see RULE8
              rd_ptr_q     <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
              rd_left_q    <= rd_left_q - {{AW{1'b0}}, 1'b1};
            end else if (!fetch_q || buf_in_ready) begin
              state_q     <= ST_IDLE;
              upload_done <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // outgoing skid buffer and registered outputs
  // ----------------------------------------
  trace_skid_buffer #(
    .WIDTH (BW)
  ) u_skid (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_data   (buf_in),
    .in_valid  (fetch_q),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out),
    .out_valid (buf_out_valid),
    .out_ready (upload_ready & ~upload_valid)
  );

  // one-entry output stage so every output is a flop
  always @(posedge mclk) begin
    if (!rst_b) begin
      upload_valid <= 1'b0;
      upload_data  <= {SAMPLE{1'b0}};
      upload_cycle <= {(AW+1){1'b0}};
    end else if (upload_valid) begin
      if (upload_ready) begin
        upload_valid <= 1'b0;
      end
    end else if (buf_out_valid && upload_ready) begin
      upload_valid <= 1'b1;
      upload_data  <= buf_out[SAMPLE-1:0];
      upload_cycle <= buf_out[BW-1:SAMPLE];
    end
  end
endmodule // trace_trigger_delay_capture
`default_nettype wire

// ### dv/trace_target_model.sv
// Purpose: target processor bus and its reset input
// Assumes: one bus cycle every third mclk
// Notes:   sample low byte is a running cycle count
`timescale 1ns/1ps
`default_nettype none
module trace_target_model #(
  parameter logic [7:0] TRIG = 8'h28
) (
  input  wire logic        mclk,
  input  wire logic        target_reset,
  output logic             bus_cycle_en,
  output logic [47:0]      bus_sample,
  output logic [5:0]       group_match
);
  logic [7:0] cnt_q = 8'h00;
  logic [1:0] ph_q  = 2'h0;
  initial bus_cycle_en = 1'b0;
  // target in reset makes no bus cycles and restarts at zero
  always @(negedge mclk) begin
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    bus_cycle_en <= ph_q == 2'h0 && !target_reset;
    if (target_reset) cnt_q <= 8'h00;
    else if (bus_cycle_en) cnt_q <= cnt_q + 8'h01;
  end
  // between cycles the bus shows junk and full matches
  assign bus_sample = {40'h0, bus_cycle_en ? cnt_q : ~cnt_q};
  assign group_match = !bus_cycle_en ? 6'h3f :
    (cnt_q == TRIG || cnt_q == TRIG + 8'h02) ? 6'h3f :
    (cnt_q == TRIG - 8'h01) ? 6'h01 : 6'h04;
endmodule // trace_target_model
`default_nettype wire

// ### dv/trace_trigger_delay_capture_bench.sv
// Purpose: self-checking bench for the trace trigger block
// Assumes: commands as one-cycle pulses set at the falling edge
// Notes:   upload entries checked against the sample count
`timescale 1ns/1ps
`default_nettype none
module trace_trigger_delay_capture_bench;
  localparam logic [7:0] TRIG = 8'h28;
  logic       mclk = 1'b0, rst_b = 1'b0, upload_ready = 1'b0;
  logic [7:0] c = 8'h00, delay_value = 8'h00, last, ex, q[$];
  logic [7:0] pv [3] = '{8'ha0, 8'h55, 8'h04};
  logic [5:0] group_program = 6'h00;
  int         n_mismatch = 0, n_compared = 0, n_neg = 0, n_tot = 0;
  int         quiet = 0;
  logic       pend = 1'b0, past_trig = 1'b0;
  wire [5:0]  group_enable, group_match;
  wire [7:0]  post_trigger_delay_count;
  wire [47:0] bus_sample, upload_data;
  wire [8:0]  upload_cycle;
  wire        reset_on_start, target_reset, armed, frozen, upload_valid;
  wire        upload_done, bus_cycle_en;
  trace_trigger_delay_capture i_trace_trigger_delay_capture (
    .mclk(mclk), .rst_b(rst_b), .bus_cycle_en(bus_cycle_en),
    .bus_sample(bus_sample), .group_match(group_match),
    .group_program(group_program), .startup(c[7]),
    .preset_trigger_at_top(c[6]), .preset_trigger_in_middle(c[5]),
    .preset_trigger_at_bottom(c[4]), .delay_write(c[3]),
    .delay_value(delay_value), .reset_on_start_set(c[2]),
    .reset_on_start_clear(c[1]), .start_capture(c[0]),
    .group_enable(group_enable),
    .post_trigger_delay_count(post_trigger_delay_count),
    .reset_on_start(reset_on_start), .target_reset(target_reset),
    .armed(armed), .frozen(frozen), .upload_data(upload_data),
    .upload_cycle(upload_cycle), .upload_valid(upload_valid),
    .upload_ready(upload_ready), .upload_done(upload_done));
  trace_target_model #(.TRIG(TRIG)) i_trace_target_model (
    .mclk(mclk), .target_reset(target_reset),
    .bus_cycle_en(bus_cycle_en), .bus_sample(bus_sample),
    .group_match(group_match));
  initial forever #4 mclk = ~mclk;
  always @(negedge mclk) upload_ready <= ($urandom % 4) != 0;
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmd(logic [7:0] v);
    @(negedge mclk) c = v;
    @(negedge mclk) c = 8'h00;
  endtask
  task automatic grp(logic [5:0] v);
    @(negedge mclk) group_program = v;
    @(negedge mclk) group_program = 6'h00;
  endtask
  task automatic run(logic [7:0] d);
    q.push_back(d);
    cmd(8'h01);
    chk("trst", {7'h0, target_reset}, {7'h0, reset_on_start});
    chk("armed", {7'h0, armed}, 8'h01);
    for (int i = 0; i < 4000 && !upload_done; i++) @(negedge mclk);
    if (!upload_done) chk("done", 8'h00, 8'h01);
    chk("frozen", {7'h0, frozen}, 8'h01);
    @(negedge mclk);
    // done flags the last word entering the buffer; let the rest drain
    for (int i = 0; i < 100 && pend; i++) @(negedge mclk);
    chk("drain", {7'h0, pend}, 8'h00);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // each taken entry, then the noted delay at the end of upload
  always @(posedge mclk) begin
    if (upload_valid && upload_ready) begin
      if (upload_data[7:0] == TRIG) past_trig = 1'b1;
      chk("cycle", upload_cycle[7:0], upload_data[7:0] - TRIG);
      chk("sign", {7'h0, upload_cycle[8]}, {7'h0, !past_trig});
      last = upload_cycle[7:0];
      n_neg += upload_cycle[8];
      n_tot++;
    end
    // two idle edges with ready high mean the buffer is empty
    quiet = (upload_valid || !upload_ready) ? 0 : quiet + 1;
    if (upload_done) begin
      pend = 1'b1;
      quiet = 0;
    end
    if (pend && quiet >= 2) begin
      ex = q.pop_front();
      chk("last", last, ex);
      if (ex == 8'h04) chk("pre", 8'(2 * n_neg > n_tot), 8'h01);
      pend = 1'b0;
      past_trig = 1'b0;
      n_neg = 0;
      n_tot = 0;
    end
  end
  initial begin
    void'($urandom(32'h9a0b));
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    chk("dly_rst", post_trigger_delay_count, 8'ha0);
    chk("ros_rst", {7'h0, reset_on_start}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      grp(6'h3f);
      cmd(8'h40 >> k);
      chk("grp_clr", {2'h0, group_enable}, 8'h00);
      chk("dly_pre", post_trigger_delay_count, pv[k]);
    end
    grp(6'h05);
    chk("grp_set", {2'h0, group_enable}, 8'h05);
    run(8'h04);
    cmd(8'h02);
    chk("ros_clr", {7'h0, reset_on_start}, 8'h00);
    delay_value = 8'h05 + 8'($urandom % 11);
    cmd(8'h08);
    chk("dly_wr", post_trigger_delay_count, delay_value);
    run(delay_value);
    cmd(8'h80);
    chk("ros_up", {7'h0, reset_on_start}, 8'h01);
    stop_test();
  end
  initial begin
    #(8 * 20000);
    n_mismatch++;
    stop_test();
  end
endmodule // trace_trigger_delay_capture_bench
`default_nettype wire

// ### dv/trace_trigger_properties.sv
// Purpose: port assertions for the trace trigger block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module trace_trigger_properties #(
  parameter GROUPS = 6,
  parameter SAMPLE = 48,
  parameter AW     = 8
) (
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              startup,
  input wire logic              preset_trigger_at_top,
  input wire logic              preset_trigger_in_middle,
  input wire logic              preset_trigger_at_bottom,
  input wire logic              delay_write,
  input wire logic [AW-1:0]     delay_value,
  input wire logic [GROUPS-1:0] group_enable,
  input wire logic [AW-1:0]     post_trigger_delay_count,
  input wire logic              reset_on_start,
  input wire logic              target_reset,
  input wire logic              armed,
  input wire logic              frozen,
  input wire logic [SAMPLE-1:0] upload_data,
  input wire logic              upload_valid,
  input wire logic              upload_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_top; preset_trigger_at_top && !delay_write |=>
    post_trigger_delay_count == 8'ha0 && !(|group_enable); endproperty
  a_top: assert property (p_top) else $error("top preset load");
  property p_mid; preset_trigger_in_middle && !delay_write |=>
    post_trigger_delay_count == 8'h55 && !(|group_enable); endproperty
  a_mid: assert property (p_mid) else $error("middle preset");
  property p_bot; preset_trigger_at_bottom && !delay_write |=>
    post_trigger_delay_count == 8'h04 && !(|group_enable); endproperty
  a_bot: assert property (p_bot) else $error("bottom preset");
  property p_write;
    delay_write |=> post_trigger_delay_count == $past(delay_value); endproperty
  a_write: assert property (p_write) else $error("delay write");
  property p_trst; $rose(armed) |-> target_reset == reset_on_start; endproperty
  a_trst: assert property (p_trst) else $error("target reset");
  // pulse is ten cycles wide
  property p_trst_len; $rose(target_reset) |-> target_reset [*8] ##1
    target_reset ##1 target_reset ##1 !target_reset; endproperty
  a_trst_len: assert property (p_trst_len) else $error("reset width");
  property p_startup; startup |=> reset_on_start; endproperty
  a_startup: assert property (p_startup) else $error("startup");
  property p_freeze; $rose(frozen) |-> !armed; endproperty
  a_freeze: assert property (p_freeze) else $error("freeze armed");
  property p_stall; upload_valid && !upload_ready |=>
    upload_valid && $stable(upload_data); endproperty
  a_stall: assert property (p_stall) else $error("upload held");
endmodule // trace_trigger_properties
bind trace_trigger_delay_capture trace_trigger_properties #(.GROUPS(GROUPS),
  .SAMPLE(SAMPLE), .AW(AW)) i_trace_trigger_properties (
  .mclk(mclk), .rst_b(rst_b), .startup(startup),
  .preset_trigger_at_top(preset_trigger_at_top),
  .preset_trigger_in_middle(preset_trigger_in_middle),
  .preset_trigger_at_bottom(preset_trigger_at_bottom),
  .delay_write(delay_write), .delay_value(delay_value),
  .group_enable(group_enable),
  .post_trigger_delay_count(post_trigger_delay_count),
  .reset_on_start(reset_on_start), .target_reset(target_reset),
  .armed(armed), .frozen(frozen), .upload_data(upload_data),
  .upload_valid(upload_valid), .upload_ready(upload_ready));
`default_nettype wire
